// file: design/gdst_pkg.sv
/*
 * Constants, state encoding and timing counts for the gate driver self-test sequencer.
 * Assumes a single 100 MHz reference clock; all rates are derived by enable pulses.
 */
// Behaviour
// - Test starts only from configuration mode
// - Test start drives irqs low, duty zero
// - Gate latched off during test and after
// - Completion: irqs high, duty ten percent
// - Stay configured, restore config defaults
// - Store per-circuit results, OR into flag
// - Test bit cleared: main irq shows result
// - Failure sets flag, records circuit, gate off
// - Fail flag ORs both domain failures
// - Query answers with ten-circuit failure map
// - Results readable anytime until reset/rerun/own domain power loss
// - Domain power cycle clears only its result
// - Neg supply mask sampled before test start
// - Wait state: main irq low, five percent
// - Duty output period is 4 kHz
// - Normal: duty 10..90 percent, irq high
// - PWM disabled while configuration mode active
package gdst_pkg;

	localparam int          CLK_HZ           = 100_000_000;
	localparam int          DUTY_FREQ_HZ     = 4_000;
	// One duty period split into 100 steps of one percent
	localparam int          DUTY_STEPS       = 100;
	localparam int          STEP_CYCLES_INT  = CLK_HZ / (DUTY_FREQ_HZ * DUTY_STEPS);
	localparam logic [7:0]  STEP_CYCLES      = STEP_CYCLES_INT[7:0];
	localparam logic [6:0]  DUTY_LAST_STEP   = 7'(DUTY_STEPS - 1);

	localparam logic [6:0]  DUTY_ZERO        = 7'h00;
	localparam logic [6:0]  DUTY_WAIT        = 7'h05;
	localparam logic [6:0]  DUTY_DONE        = 7'h0a;
	localparam logic [6:0]  DUTY_MIN         = 7'h0a;
	localparam logic [6:0]  DUTY_MAX         = 7'h5a;

	localparam int          TEST_TIME_MS     = 28;
	localparam int          TEST_CYCLES_DEF  = TEST_TIME_MS * (CLK_HZ / 1000);

	localparam int          NUM_CIRCUITS     = 10;
	localparam int          LV_CIRCUITS      = 5;
	// Negative supply monitor sits in the HV half of the result map
	localparam int          NEG_SUPPLY_BIT   = 6;
	localparam logic [9:0]  LV_MASK          = 10'h01f;
	localparam logic [9:0]  HV_MASK          = 10'h3e0;
	localparam logic [9:0]  RESULT_CLEAR     = 10'h000;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN  = 2'b01,
		ST_DONE = 2'b10
	} gdst_state_t;

endpackage : gdst_pkg

// file: design/gdst_sequencer.sv
/*
 * Self-test sequencer: test entry gating, progress signatures on the interrupt and
 * duty-cycle pins, result record, default restore and gate inhibit.
 * Assumes the analog test engine reports per-circuit failures as a 10-bit level that is
 * valid while its done input is high, and that domain power-good inputs are synchronous.
 */
`timescale 1ns/1ps

module gdst_sequencer #(
	parameter int TEST_CYCLES = gdst_pkg::TEST_CYCLES_DEF
) (
	input  wire logic       ref_clk_i,
	input  wire logic       resetn_i,
	input  wire logic       lv_power_good_i,
	input  wire logic       hv_power_good_i,
	input  wire logic       config_enable_i,
	input  wire logic       self_test_run_bit_i,
	input  wire logic       neg_supply_range_mask_i,
	input  wire logic       pwm_i,
	input  wire logic       fault_present_i,
	input  wire logic [6:0] temp_sense_duty_i,
	input  wire logic [9:0] circuit_fail_i,
	input  wire logic       self_test_result_query_i,
	output logic            main_fault_irq_out_o,
	output logic            aux_fault_irq_out_o,
	output logic            duty_cycle_report_out_o,
	output logic            gate_on_o,
	output logic            test_active_o,
	output logic            config_defaults_load_o,
	output logic            neg_test_enable_o,
	output logic            self_test_fail_flag_o,
	output logic [9:0]      self_test_result_o,
	output logic            result_valid_o,
	output logic [9:0]      query_response_o,
	output logic            query_valid_o
);
	import gdst_pkg::*;

	gdst_state_t  state_reg;
	gdst_state_t  state_next;
	logic [31:0]  timer_reg;
	logic         run_bit_d_reg;
	logic         gate_inhibit_reg;
	logic [9:0]   result_reg;
	logic         neg_en_reg;
	logic [7:0]   step_cnt_reg;
	logic [6:0]   phase_reg;
	logic [6:0]   duty_sel;
	logic         step_en;
	logic         start_req;
	logic         test_done;
	logic         fail_any;

	function automatic logic [6:0] clamp_duty(input logic [6:0] d);
		if (d < DUTY_MIN)
			return DUTY_MIN;
		if (d > DUTY_MAX)
			return DUTY_MAX;
		return d;
	endfunction : clamp_duty

	// Rising test bit with configuration mode
	assign start_req = self_test_run_bit_i && !run_bit_d_reg && config_enable_i && state_reg != ST_RUN;
	assign test_done = state_reg == ST_RUN && timer_reg >= 32'(TEST_CYCLES - 1);
	assign fail_any  = |(result_reg & LV_MASK) || |(result_reg & HV_MASK);

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			run_bit_d_reg <= 1'b0;
		else
			run_bit_d_reg <= self_test_run_bit_i;
	end

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (start_req)
					state_next = ST_RUN;
			end
			ST_RUN: begin
				if (test_done)
					state_next = ST_DONE;
			end
			ST_DONE: begin
				if (start_req)
					state_next = ST_RUN;
				else if (!self_test_run_bit_i)
					state_next = ST_IDLE;
			end
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			state_reg <= ST_IDLE;
		else if (!lv_power_good_i)
			state_reg <= ST_IDLE;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			timer_reg <= 32'h0000_0000;
		else if (state_reg != ST_RUN)
			timer_reg <= 32'h0000_0000;
		else
			timer_reg <= timer_reg + 32'h0000_0001;
	end

	// Mask captured as the test starts
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			neg_en_reg <= 1'b0;
		else if (start_req && state_reg == ST_IDLE || start_req && state_reg == ST_DONE)
			neg_en_reg <= neg_supply_range_mask_i;
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			result_reg <= RESULT_CLEAR;
		end else begin
			// Each domain clears only its half
			if (!lv_power_good_i)
				result_reg <= result_reg & HV_MASK;
			else if (!hv_power_good_i)
				result_reg <= result_reg & LV_MASK;
			else if (start_req)
				result_reg <= RESULT_CLEAR;
			else if (test_done) begin
				result_reg <= circuit_fail_i;
				if (!neg_en_reg)
					result_reg[NEG_SUPPLY_BIT] <= 1'b0;
			end
		end
	end

	// Gate latched off until test bit clear and config left
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			gate_inhibit_reg <= 1'b0;
		else if (start_req)
			gate_inhibit_reg <= 1'b1;
		else if (state_reg == ST_IDLE && !self_test_run_bit_i && !config_enable_i)
			gate_inhibit_reg <= 1'b0;
	end

	// Failure forces gate off; no PWM in configuration
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			gate_on_o <= 1'b0;
		else
			gate_on_o <= pwm_i && !config_enable_i && !gate_inhibit_reg && !fail_any
				&& lv_power_good_i && hv_power_good_i && state_reg == ST_IDLE;
	end

	// One percent step enable for the 4 kHz period
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			step_cnt_reg <= 8'h00;
		else if (step_en)
			step_cnt_reg <= 8'h00;
		else
			step_cnt_reg <= step_cnt_reg + 8'h01;
	end
	assign step_en = step_cnt_reg == STEP_CYCLES - 8'h01;

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			phase_reg <= 7'h00;
		else if (step_en)
			phase_reg <= (phase_reg == DUTY_LAST_STEP) ? 7'h00 : phase_reg + 7'h01;
	end

	always_comb begin
		if (state_reg == ST_RUN)
			duty_sel = DUTY_ZERO;
		else if (state_reg == ST_DONE)
			duty_sel = DUTY_DONE;
		else if (!hv_power_good_i)
			duty_sel = DUTY_WAIT;
		else
			duty_sel = clamp_duty(temp_sense_duty_i);
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			duty_cycle_report_out_o <= 1'b0;
		else
			duty_cycle_report_out_o <= phase_reg < duty_sel;
	end

	// Main irq carries the result once the test bit is cleared
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			main_fault_irq_out_o <= 1'b0;
			aux_fault_irq_out_o  <= 1'b0;
		end else if (state_reg == ST_RUN || start_req) begin
			main_fault_irq_out_o <= 1'b0;
			aux_fault_irq_out_o  <= 1'b0;
		end else if (state_reg == ST_DONE) begin
			main_fault_irq_out_o <= 1'b1;
			aux_fault_irq_out_o  <= 1'b1;
		end else if (!hv_power_good_i) begin
			main_fault_irq_out_o <= 1'b0;
			aux_fault_irq_out_o  <= !fault_present_i;
		end else begin
			// Failed result pulls main irq low, in or out of configuration
			main_fault_irq_out_o <= !fault_present_i && !fail_any;
			aux_fault_irq_out_o  <= !fault_present_i;
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			config_defaults_load_o <= 1'b0;
		else
			config_defaults_load_o <= test_done;
	end

	// Query response with the failure map
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			query_response_o <= RESULT_CLEAR;
			query_valid_o    <= 1'b0;
		end else begin
			query_valid_o <= self_test_result_query_i;
			if (self_test_result_query_i)
				query_response_o <= result_reg;
		end
	end

	// Results stay visible until reset, rerun or power loss of their domain
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			self_test_result_o    <= RESULT_CLEAR;
			self_test_fail_flag_o <= 1'b0;
			result_valid_o        <= 1'b0;
			test_active_o         <= 1'b0;
			neg_test_enable_o     <= 1'b0;
		end else begin
			self_test_result_o    <= result_reg;
			self_test_fail_flag_o <= fail_any;
			result_valid_o        <= state_reg == ST_DONE || (state_reg == ST_IDLE && result_valid_o && !start_req);
			test_active_o         <= state_reg == ST_RUN;
			neg_test_enable_o     <= neg_en_reg;
		end
	end

	a_start_gating: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		state_reg == ST_IDLE && state_next == ST_RUN |-> config_enable_i)
		else $error("test started outside configuration mode");

	a_run_irq_low: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		state_reg == ST_RUN ##1 state_reg == ST_RUN |-> !main_fault_irq_out_o && !aux_fault_irq_out_o)
		else $error("irq high during test");

	a_run_duty_zero: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		state_reg == ST_RUN ##1 state_reg == ST_RUN |-> !duty_cycle_report_out_o)
		else $error("duty output high during test");

	a_gate_off_test: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		state_reg == ST_RUN |=> !gate_on_o)
		else $error("gate on during test");

	a_done_irq_high: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		state_reg == ST_DONE && $past(state_reg) == ST_DONE |=> main_fault_irq_out_o && aux_fault_irq_out_o)
		else $error("irqs not high after completion");

	a_defaults_pulse: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		test_done |=> config_defaults_load_o ##1 !config_defaults_load_o)
		else $error("default restore pulse wrong");

	a_flag_or: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		1'b1 |=> self_test_fail_flag_o == $past(|result_reg))
		else $error("fail flag is not the OR of results");

	a_fail_irq_low: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		state_reg == ST_IDLE && hv_power_good_i && fail_any && !start_req |=> !main_fault_irq_out_o)
		else $error("main irq high despite failure");

	a_query_answer: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		self_test_result_query_i |=> query_valid_o && query_response_o == $past(result_reg))
		else $error("query answer wrong");

	a_no_restart: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		state_reg == ST_RUN && !test_done && lv_power_good_i |=> state_reg == ST_RUN && timer_reg != 32'h0)
		else $error("running test restarted");

	c_pass_run:   cover property (@(posedge ref_clk_i) disable iff (!resetn_i) test_done && circuit_fail_i == 10'h000);
	c_fail_run:   cover property (@(posedge ref_clk_i) disable iff (!resetn_i) test_done && circuit_fail_i != 10'h000);
	c_exit_test:  cover property (@(posedge ref_clk_i) disable iff (!resetn_i) state_reg == ST_DONE ##1 state_reg == ST_IDLE);
	c_wait_state: cover property (@(posedge ref_clk_i) disable iff (!resetn_i) lv_power_good_i && !hv_power_good_i);

endmodule : gdst_sequencer

// file: test/gdst_host_model.sv
/*
 * Host-side monitor of the duty-cycle report pin: measures high time and period in clock cycles.
 * Assumes the pin is sampled on the sequencer's reference clock; a host timer does the same job.
 */
`timescale 1ns/1ps

module gdst_host_model (
	input  wire logic        ref_clk_i,
	input  wire logic        resetn_i,
	input  wire logic        duty_i,
	output logic      [15:0] high_o,
	output logic      [15:0] period_o,
	output logic      [15:0] rises_o,
	output logic      [15:0] falls_o
);
	logic        prev_reg;
	logic [15:0] per_reg;
	logic [15:0] hi_reg;

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			prev_reg <= 1'b0;
			per_reg  <= 16'h0000;
			hi_reg   <= 16'h0000;
			high_o   <= 16'h0000;
			period_o <= 16'h0000;
			rises_o  <= 16'h0000;
			falls_o  <= 16'h0000;
		end else begin
			prev_reg <= duty_i;
			per_reg  <= (duty_i && !prev_reg) ? 16'h0001 : per_reg + 16'h0001;
			if (duty_i) begin
				hi_reg <= prev_reg ? hi_reg + 16'h0001 : 16'h0001;
			end
			if (duty_i && !prev_reg) begin
				period_o <= per_reg;
				rises_o  <= rises_o + 16'h0001;
			end
			if (!duty_i && prev_reg) begin
				high_o  <= hi_reg;
				falls_o <= falls_o + 16'h0001;
			end
		end
	end
endmodule : gdst_host_model

// file: test/tb_gdst_sequencer.sv
/*
 * Self-checking bench for the self-test sequencer: wait state, normal mode, pass and fail runs.
 * Assumes a shortened run length of 50 cycles; duty figures stay at the real 4 kHz rate.
 */
`timescale 1ns/1ps

module tb_gdst_sequencer;
	import gdst_pkg::*;
	localparam int LIMIT = 150000;
	logic        ref_clk_i, resetn_i, lv_pg, hv_pg, cfg, run_bit, neg_mask, pwm, fault, query, seen;
	logic [6:0]  temp;
	logic [9:0]  cfail, result, qresp;
	logic        main_irq, aux_irq, duty, gate_on, active, dload, neg_en, fflag, rvalid, qvalid;
	logic [15:0] m_high, m_per, m_rise, m_fall;
	int          err_total, tests_run, cycles, hi;

	gdst_sequencer #(.TEST_CYCLES(50)) i_gdst_sequencer (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
		.lv_power_good_i(lv_pg), .hv_power_good_i(hv_pg), .config_enable_i(cfg),
		.self_test_run_bit_i(run_bit), .neg_supply_range_mask_i(neg_mask), .pwm_i(pwm),
		.fault_present_i(fault), .temp_sense_duty_i(temp), .circuit_fail_i(cfail),
		.self_test_result_query_i(query), .main_fault_irq_out_o(main_irq), .aux_fault_irq_out_o(aux_irq),
		.duty_cycle_report_out_o(duty), .gate_on_o(gate_on), .test_active_o(active),
		.config_defaults_load_o(dload), .neg_test_enable_o(neg_en), .self_test_fail_flag_o(fflag),
		.self_test_result_o(result), .result_valid_o(rvalid), .query_response_o(qresp),
		.query_valid_o(qvalid));

	gdst_host_model i_gdst_host_model (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .duty_i(duty),
		.high_o(m_high), .period_o(m_per), .rises_o(m_rise), .falls_o(m_fall));

	task end_of_test;
		$display("tests_run=%0d err_total=%0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test

	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task tick(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask : tick

	// Waits for a whole high pulse; the period needs one more rising edge
	task duty_meas(input logic [31:0] exp_hi, input logic [31:0] exp_per);
		logic [15:0] mark;
		int          k;
		mark = m_rise;
		k = 0;
		while (m_rise === mark && k < 30000) begin tick(1); k++; end
		mark = m_fall;
		while (m_fall === mark && k < 60000) begin tick(1); k++; end
		chk(m_fall, mark + 16'h0001);
		chk(m_high, exp_hi);
		if (exp_per != 0) begin
			mark = m_rise;
			while (m_rise === mark && k < 90000) begin tick(1); k++; end
			chk(m_rise, mark + 16'h0001);
			chk(m_per, exp_per);
		end
	endtask : duty_meas

	// The defaults pulse is caught the cycle before the irqs come back high
	task wait_done;
		int k;
		seen = 1'b0;
		for (k = 0; k < 300 && main_irq !== 1'b1; k++) begin
			tick(1);
			if (dload === 1'b1) seen = 1'b1;
		end
		tick(1);
		if (dload === 1'b1) seen = 1'b1;
	endtask : wait_done

	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == LIMIT) begin
			err_total++;
			end_of_test;
		end
	end

	initial begin
		resetn_i = 1'b0; lv_pg = 1'b1; hv_pg = 1'b0; cfg = 1'b0; run_bit = 1'b0; neg_mask = 1'b0;
		pwm = 1'b0; fault = 1'b0; query = 1'b0; temp = 7'h03; cfail = 10'h000;
		tick(5);
		resetn_i = 1'b1;
		tick(2);
		chk(main_irq, 1'b0);
		duty_meas(32'h4e2, 32'h61a8);
		$display("test wait_state done");
		// watchdog fault pulls the aux irq low while HV is down
		fault = 1'b1;
		tick(3);
		chk({main_irq, aux_irq}, 2'h0);
		hv_pg = 1'b1;
		tick(3);
		chk(main_irq, 1'b0);
		fault = 1'b0;
		tick(3);
		chk(main_irq, 1'b1);
		run_bit = 1'b1;
		tick(4);
		chk(active, 1'b0);
		run_bit = 1'b0;
		$display("test normal_and_refusal done");
		cfg = 1'b1; neg_mask = 1'b1; pwm = 1'b1;
		tick(2);
		run_bit = 1'b1;
		tick(3);
		chk({active, main_irq, aux_irq, gate_on, neg_en}, 5'h11);
		hi = 0;
		repeat (30) begin if (duty !== 1'b0) hi++; tick(1); end
		chk(hi, 0);
		wait_done();
		chk({seen, aux_irq, fflag, result, rvalid}, {3'h6, 10'h000, 1'b1});
		duty_meas(32'h9c4, 32'h0);
		run_bit = 1'b0;
		tick(3);
		chk({main_irq, gate_on}, 2'h2);
		cfg = 1'b0;
		tick(3);
		chk(gate_on, 1'b1);
		duty_meas(32'h9c4, 32'h0);
		$display("test pass_run done");
		cfg = 1'b1; neg_mask = 1'b0;
		tick(2);
		run_bit = 1'b1;
		tick(3);
		chk(neg_en, 1'b0);
		run_bit = 1'b0;
		tick(1);
		run_bit = 1'b1;
		tick(2);
		chk(active, 1'b1);
		cfail = 10'h061;
		wait_done();
		chk({fflag, result}, {1'b1, 10'h021});
		query = 1'b1;
		tick(1);
		chk({qvalid, qresp}, {1'b1, 10'h021});
		query = 1'b0;
		tick(1);
		chk(qvalid, 1'b0);
		run_bit = 1'b0;
		tick(3);
		chk(main_irq, 1'b0);
		cfg = 1'b0;
		tick(3);
		chk(gate_on, 1'b0);
		lv_pg = 1'b0;
		tick(3);
		lv_pg = 1'b1;
		tick(3);
		chk({fflag, result}, {1'b1, 10'h020});
		hv_pg = 1'b0;
		tick(3);
		hv_pg = 1'b1;
		tick(3);
		chk({fflag, result}, {1'b0, 10'h000});
		$display("test fail_run done");
		end_of_test;
	end
endmodule : tb_gdst_sequencer
